// *** hdl/oam_remote_command_regs.sv ***
`timescale 1ns/1ps
module oam_remote_command_regs
    import oam_rc_pkg::*;
(
    input  wire logic         core_clk_i,
    input  wire logic         rstn_i,
    input  wire logic [9:0]   avs_address_i,
    input  wire logic         avs_read_i,
    input  wire logic         avs_write_i,
    input  wire logic [31:0]  avs_writedata_i,
    input  wire logic [3:0]   avs_byteenable_i,
    output logic [31:0]       avs_readdata_o,
    output logic              avs_waitrequest_o,
    output logic [7:0]        frame_byte0_o,
    output logic [7:0]        frame_byte1_o,
    output logic [7:0]        frame_byte2_o,
    output rc_cmd_t           cmd_o
);

    logic       rsvd_q;
    logic       read_ack_q;
    logic [1:0] op_code_q;
    logic [1:0] op_mode_q;
    logic [7:0] address_q;
    logic [7:0] data_q;
    logic [7:0] model0_q;
    logic [7:0] model1_q;
    logic [7:0] model2_q;
    logic [31:0] readdata_q;
    logic [31:0] readdata_d;
    logic [7:0] frame0_q;
    logic [7:0] frame1_q;
    logic [7:0] frame2_q;

    logic       access;
    logic       rd_phase;

    rc_avl_slave u_slave (
        .core_clk_i    (core_clk_i),
        .rstn_i        (rstn_i),
        .read_i        (avs_read_i),
        .write_i       (avs_write_i),
        .waitrequest_o (avs_waitrequest_o),
        .access_o      (access),
        .rd_phase_o    (rd_phase)
    );

    // Word address decode; low two bits select nothing since each register is one word
    wire [7:0] widx      = avs_address_i[9:2];
    wire       wr_stb    = access & avs_write_i & avs_byteenable_i[0];
    wire [7:0] wbyte     = avs_writedata_i[7:0];
    wire       hit_ctrl  = (widx == IDX_RC_CONTROL);
    wire       hit_addr  = (widx == IDX_RC_ADDRESS);
    wire       hit_data  = (widx == IDX_RC_DATA);
    wire       hit_m0    = (widx == IDX_MODEL_INFO);
    wire       hit_m1    = (widx == IDX_MODEL_ADDR);
    wire       hit_m2    = (widx == IDX_MODEL_DATA);

    wire [7:0] ctrl_byte = {rsvd_q, read_ack_q, RST_CAP, op_code_q, op_mode_q};

    rc_ctrl_t ctrl;
    assign ctrl.read_ack = read_ack_q;
    assign ctrl.op_code  = op_code_q;
    assign ctrl.op_mode  = op_mode_q;

    frame_bytes_t model;
    assign model.byte0 = model0_q;
    assign model.byte1 = model1_q;
    assign model.byte2 = model2_q;

    frame_bytes_t frame;
    rc_cmd_t      cmd_c;

    rc_frame_mux u_mux (
        .ctrl_i       (ctrl),
        .ctrl_byte_i  (ctrl_byte),
        .rc_address_i (address_q),
        .rc_data_i    (data_q),
        .model_i      (model),
        .frame_o      (frame),
        .cmd_o        (cmd_c)
    );

    // Unmapped addresses read as zero and ignore writes
    always_comb
    begin
        readdata_d = 32'h0;
        if (hit_ctrl)
            readdata_d[7:0] = ctrl_byte;
        else if (hit_addr)
            readdata_d[7:0] = address_q;
        else if (hit_data)
            readdata_d[7:0] = data_q;
        else if (hit_m0)
            readdata_d[7:0] = model0_q;
        else if (hit_m1)
            readdata_d[7:0] = model1_q;
        else if (hit_m2)
            readdata_d[7:0] = model2_q;
    end

    // Mode field takes whatever is written; reserved encodings are the writer's duty
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            rsvd_q     <= 1'b0;
            read_ack_q <= 1'b0;
            op_code_q  <= RST_OP_CODE;
            op_mode_q  <= RST_OP_MODE;
        end
        else if (wr_stb && hit_ctrl)
        begin
            rsvd_q     <= wbyte[RSVD_BIT];
            read_ack_q <= wbyte[READ_ACK_BIT];
            op_code_q  <= wbyte[OP_CODE_LSB +: 2];
            op_mode_q  <= wbyte[OP_MODE_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            address_q <= RST_ADDRESS;
            data_q    <= RST_DATA;
        end
        else
        begin
            if (wr_stb && hit_addr)
                address_q <= wbyte;
            if (wr_stb && hit_data)
                data_q <= wbyte;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            model0_q <= RST_MODEL;
            model1_q <= RST_MODEL;
            model2_q <= RST_MODEL;
        end
        else
        begin
            if (wr_stb && hit_m0)
                model0_q <= wbyte;
            if (wr_stb && hit_m1)
                model1_q <= wbyte;
            if (wr_stb && hit_m2)
                model2_q <= wbyte;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
            readdata_q <= 32'h0;
        else if (rd_phase)
            readdata_q <= readdata_d;
    end

    // Frame bytes are registered so the frame builder sees glitch-free data
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            frame0_q <= 8'h0;
            frame1_q <= 8'h0;
            frame2_q <= 8'h0;
            cmd_o    <= CMD_NONE;
        end
        else
        begin
            frame0_q <= frame.byte0;
            frame1_q <= frame.byte1;
            frame2_q <= frame.byte2;
            cmd_o    <= cmd_c;
        end
    end

    assign avs_readdata_o = readdata_q;
    assign frame_byte0_o  = frame0_q;
    assign frame_byte1_o  = frame1_q;
    assign frame_byte2_o  = frame2_q;

    property p_ext_addr;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (op_mode_q == OP_MODE_EXTENDED) |=> (frame_byte1_o == $past(address_q));
    endproperty
    a_ext_addr: assert property (p_ext_addr) else $error("address byte not in frame");

    property p_ext_data;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (op_mode_q == OP_MODE_EXTENDED) |=> (frame_byte2_o == $past(data_q));
    endproperty
    a_ext_data: assert property (p_ext_data) else $error("data byte not in frame");

    property p_ext_ctrl;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (op_mode_q == OP_MODE_EXTENDED) |=> (frame_byte0_o[1:0] == OP_MODE_EXTENDED);
    endproperty
    a_ext_ctrl: assert property (p_ext_ctrl) else $error("control byte not in frame");

    property p_norm;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (op_mode_q == OP_MODE_NORMAL) |=>
            (frame_byte0_o == $past(model0_q)) && (frame_byte2_o == $past(model2_q));
    endproperty
    a_norm: assert property (p_norm) else $error("model bytes not in frame");

    property p_code;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (op_mode_q == OP_MODE_EXTENDED && op_code_q == OP_CODE_WRITE_REQ)
            |=> (cmd_o == CMD_WRITE_REQUEST);
    endproperty
    a_code: assert property (p_code) else $error("write request not decoded");

    property p_ack;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (op_mode_q == OP_MODE_EXTENDED && op_code_q == OP_CODE_READ_REQ)
            |=> (cmd_o == ($past(read_ack_q) ? CMD_READ_ACK : CMD_READ_REQUEST));
    endproperty
    a_ack: assert property (p_ack) else $error("read ack decode wrong");

    property p_reset;
        @(posedge core_clk_i)
        !rstn_i |=> (op_mode_q == OP_MODE_EXTENDED) && (address_q == 8'h0) && (data_q == 8'h0);
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");

    property p_addr_wr;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (wr_stb && hit_addr) |=> ##1 (frame_byte1_o == $past(wbyte, 2))
            || ($past(op_mode_q) != OP_MODE_EXTENDED);
    endproperty
    a_addr_wr: assert property (p_addr_wr) else $error("address write lost");

    property p_data_wr;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (wr_stb && hit_data) |=> (data_q == $past(wbyte));
    endproperty
    a_data_wr: assert property (p_data_wr) else $error("data write lost");

    property p_cmd_none;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (op_mode_q != OP_MODE_EXTENDED) |=> (cmd_o == CMD_NONE);
    endproperty
    a_cmd_none: assert property (p_cmd_none) else $error("stray command");

    property p_rd_reply;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (op_mode_q == OP_MODE_EXTENDED && op_code_q == OP_CODE_READ_REPLY)
            |=> (cmd_o == CMD_READ_REPLY);
    endproperty
    a_rd_reply: assert property (p_rd_reply) else $error("read reply not decoded");

    property p_wr_reply;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (op_mode_q == OP_MODE_EXTENDED && op_code_q == OP_CODE_WRITE_REPLY)
            |=> (cmd_o == CMD_WRITE_REPLY);
    endproperty
    a_wr_reply: assert property (p_wr_reply) else $error("write reply not decoded");

    property p_norm_addr;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (op_mode_q == OP_MODE_NORMAL) |=> (frame_byte1_o == $past(model1_q));
    endproperty
    a_norm_addr: assert property (p_norm_addr) else $error("model byte 1 not in frame");

    property p_ext_code;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (op_mode_q == OP_MODE_EXTENDED) |=> (frame_byte0_o[3:2] == $past(op_code_q));
    endproperty
    a_ext_code: assert property (p_ext_code) else $error("op code not in frame");

    property p_data_frame;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (wr_stb && hit_data) |=> ##1 (frame_byte2_o == $past(wbyte, 2))
            || ($past(op_mode_q) != OP_MODE_EXTENDED);
    endproperty
    a_data_frame: assert property (p_data_frame) else $error("data write not framed");

    // Address and data only move on a bus write, so a command cannot pick up stale bytes
    property p_addr_hold;
        @(posedge core_clk_i) disable iff (!rstn_i)
        !(wr_stb && hit_addr) |=> $stable(address_q);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address changed unasked");

    property p_data_hold;
        @(posedge core_clk_i) disable iff (!rstn_i)
        !(wr_stb && hit_data) |=> $stable(data_q);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data changed unasked");

    property p_reset_code;
        @(posedge core_clk_i)
        !rstn_i |=> (op_code_q == RST_OP_CODE) && !read_ack_q;
    endproperty
    a_reset_code: assert property (p_reset_code) else $error("op code reset wrong");

endmodule

// *** inc/oam_rc_pkg.sv ***
package oam_rc_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_RC_CONTROL = 8'h4a;
    localparam logic [7:0] IDX_RC_ADDRESS = 8'h4b;
    localparam logic [7:0] IDX_RC_DATA    = 8'h4c;
    localparam logic [7:0] IDX_MODEL_INFO = 8'h55;
    localparam logic [7:0] IDX_MODEL_ADDR = 8'h56;
    localparam logic [7:0] IDX_MODEL_DATA = 8'h57;
    localparam logic [7:0] IDX_RC_ISSUE   = 8'h42;

    // Field positions in the control register
    localparam int OP_MODE_LSB  = 0;
    localparam int OP_CODE_LSB  = 2;
    localparam int CAP_LSB      = 4;
    localparam int READ_ACK_BIT = 6;
    localparam int RSVD_BIT     = 7;

    localparam logic [1:0] OP_MODE_NORMAL   = 2'h0;
    localparam logic [1:0] OP_MODE_EXTENDED = 2'h2;

    localparam logic [1:0] OP_CODE_READ_REPLY  = 2'h0;
    localparam logic [1:0] OP_CODE_READ_REQ    = 2'h1;
    localparam logic [1:0] OP_CODE_WRITE_REPLY = 2'h2;
    localparam logic [1:0] OP_CODE_WRITE_REQ   = 2'h3;

    // Reset values
    localparam logic [1:0] RST_OP_MODE  = OP_MODE_EXTENDED;
    localparam logic [1:0] RST_OP_CODE  = 2'h0;
    localparam logic [1:0] RST_CAP      = 2'h2;
    localparam logic [7:0] RST_ADDRESS  = 8'h00;
    localparam logic [7:0] RST_DATA     = 8'h00;
    localparam logic [7:0] RST_MODEL    = 8'h00;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_READ_REPLY,
        CMD_READ_REQUEST,
        CMD_READ_ACK,
        CMD_WRITE_REPLY,
        CMD_WRITE_REQUEST
    } rc_cmd_t;

    typedef struct packed {
        logic       read_ack;
        logic [1:0] op_code;
        logic [1:0] op_mode;
    } rc_ctrl_t;

    typedef struct packed {
        logic       read;
        logic       write;
        logic [9:0] address;
        logic [31:0] writedata;
    } avl_req_t;

    typedef struct packed {
        logic [7:0] byte0;
        logic [7:0] byte1;
        logic [7:0] byte2;
    } frame_bytes_t;

endpackage

// *** hdl/rc_frame_mux.sv ***
`timescale 1ns/1ps
module rc_frame_mux
    import oam_rc_pkg::*;
(
    input  wire rc_ctrl_t     ctrl_i,
    input  wire logic [7:0]   ctrl_byte_i,
    input  wire logic [7:0]   rc_address_i,
    input  wire logic [7:0]   rc_data_i,
    input  wire frame_bytes_t model_i,
    output frame_bytes_t      frame_o,
    output rc_cmd_t           cmd_o
);

    wire extended = (ctrl_i.op_mode == OP_MODE_EXTENDED);

    // Reserved modes fall back to the model bytes, the safer of the two
    assign frame_o.byte0 = extended ? ctrl_byte_i : model_i.byte0;
    assign frame_o.byte1 = extended ? rc_address_i : model_i.byte1;
    assign frame_o.byte2 = extended ? rc_data_i : model_i.byte2;

    function automatic rc_cmd_t decode_cmd(input rc_ctrl_t c);
        if (c.op_mode != OP_MODE_EXTENDED)
            return CMD_NONE;
        case (c.op_code)
            OP_CODE_READ_REPLY:  return CMD_READ_REPLY;
            OP_CODE_READ_REQ:    return c.read_ack ? CMD_READ_ACK : CMD_READ_REQUEST;
            OP_CODE_WRITE_REPLY: return CMD_WRITE_REPLY;
            default:             return CMD_WRITE_REQUEST;
        endcase
    endfunction

    assign cmd_o = decode_cmd(ctrl_i);

endmodule

// *** hdl/rc_avl_slave.sv ***
`timescale 1ns/1ps
module rc_avl_slave
    import oam_rc_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       read_i,
    input  wire logic       write_i,
    output logic            waitrequest_o,
    output logic            access_o,
    output logic            rd_phase_o
);

    // One wait cycle per access gives registered read data time to settle
    logic busy_q;
    logic busy_d;

    wire req = read_i | write_i;

    assign busy_d        = req & ~busy_q;
    assign waitrequest_o = req & ~busy_q;
    assign access_o      = req & busy_q;
    assign rd_phase_o    = read_i & ~busy_q;

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
            busy_q <= 1'b0;
        else
            busy_q <= busy_d;
    end

endmodule

// *** verif/rc_far_end.sv ***
`timescale 1ns/1ps
module rc_far_end
    import oam_rc_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic [7:0] frame_byte1_i,
    input  wire logic [7:0] frame_byte2_i,
    input  wire rc_cmd_t    cmd_i,
    output logic [7:0]      far_addr_o,
    output logic [7:0]      far_data_o
);
    // Remote end trusts address and data only when a command is carried
    always_ff @(posedge core_clk_i)
    begin
        if (cmd_i != CMD_NONE)
        begin
            far_addr_o <= frame_byte1_i;
            far_data_o <= frame_byte2_i;
        end
    end
endmodule

// *** verif/oam_remote_command_regs_tb.sv ***
`timescale 1ns/1ps
module oam_remote_command_regs_tb;
    import oam_rc_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        rstn_i     = 1'b0;
    logic [9:0]  adr        = 10'h000;
    logic        rd_en      = 1'b0;
    logic        wr_en      = 1'b0;
    logic [31:0] wdat       = 32'h0;
    logic [3:0]  be         = 4'hf;
    logic [31:0] rdat;
    logic [31:0] r;
    logic        wreq;
    logic [7:0]  fb0, fb1, fb2, far_a, far_d, c, a, d;
    logic [7:0]  m [3];
    rc_cmd_t     cmd;
    int          n_fail     = 0;
    int          num_checks = 0;
    logic [15:0] lf         = 16'hb92d;

    oam_remote_command_regs dut_u (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .avs_address_i(adr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat),
        .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .frame_byte0_o(fb0), .frame_byte1_o(fb1), .frame_byte2_o(fb2), .cmd_o(cmd));

    rc_far_end far_u (
        .core_clk_i(core_clk_i), .frame_byte1_i(fb1), .frame_byte2_i(fb2),
        .cmd_i(cmd), .far_addr_o(far_a), .far_data_o(far_d));

    initial
    begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    function automatic logic [7:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf[7:0];
    endfunction

    function automatic rc_cmd_t exp_cmd(logic [7:0] cv);
        if (cv[1:0] != OP_MODE_EXTENDED)
            return CMD_NONE;
        case (cv[3:2])
            OP_CODE_READ_REPLY:  return CMD_READ_REPLY;
            OP_CODE_READ_REQ:    return cv[6] ? CMD_READ_ACK : CMD_READ_REQUEST;
            OP_CODE_WRITE_REPLY: return CMD_WRITE_REPLY;
            default:             return CMD_WRITE_REQUEST;
        endcase
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] v);
        int   n;
        logic busy;
        n = 0;
        busy = 1'b1;
        adr <= {idx, 2'b00};
        wr_en <= w;
        rd_en <= !w;
        wdat <= {24'h0, v};
        while (busy)
        begin
            // Woken at the edge before its updates land: these are the sampled values
            @(posedge core_clk_i);
            busy = wreq;
            r = rdat;
            n++;
            if (n > 50)
            begin
                n_fail++;
                test_done();
            end
        end
    endtask

    task automatic idle();
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk(what, r, {24'h0, e});
    endtask

    // Frame and command settle one edge after the last write, long before this
    task automatic outchk(input logic [7:0] cv, input logic [7:0] av, input logic [7:0] dv);
        logic [7:0]  rb;
        logic [31:0] ef;
        rb = {cv[7:6], 2'b10, cv[3:0]};
        ef = (cv[1:0] == OP_MODE_EXTENDED) ? {8'h0, dv, av, rb} : {8'h0, m[2], m[1], m[0]};
        @(negedge core_clk_i);
        chk("frame", {8'h0, fb2, fb1, fb0}, ef);
        chk("cmd", {29'h0, cmd}, {29'h0, exp_cmd(cv)});
        if (cv[1:0] == OP_MODE_EXTENDED)
        begin
            chk("far_addr", {24'h0, far_a}, {24'h0, av});
            chk("far_data", {24'h0, far_d}, {24'h0, dv});
        end
        @(posedge core_clk_i);
    endtask

    initial
    begin
        repeat (5000) @(posedge core_clk_i);
        n_fail++;
        test_done();
    end

    initial
    begin
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        @(posedge core_clk_i);
        rdchk("ctrl_rst", IDX_RC_CONTROL, 8'h22);
        rdchk("addr_rst", IDX_RC_ADDRESS, 8'h00);
        rdchk("data_rst", IDX_RC_DATA, 8'h00);
        idle();
        outchk(8'h22, 8'h00, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 32; i++)
        begin
            c = {1'b0, i[4], i[3:2], i[1], 1'b0};
            a = rnd();
            d = rnd();
            for (int k = 0; k < 3; k++)
            begin
                m[k] = rnd();
                bus(1'b1, IDX_MODEL_INFO + k[7:0], m[k]);
            end
            // Only normal or extended mode is written; the other encodings are off limits
            bus(1'b1, IDX_RC_CONTROL, c);
            bus(1'b1, IDX_RC_ADDRESS, a);
            bus(1'b1, IDX_RC_DATA, d);
            rdchk("ctrl", IDX_RC_CONTROL, {c[7:6], 2'b10, c[3:0]});
            rdchk("addr", IDX_RC_ADDRESS, a);
            rdchk("data", IDX_RC_DATA, d);
            idle();
            outchk(c, a, d);
            $display("test %0d done", i);
        end
        be <= 4'he;
        bus(1'b1, IDX_RC_ADDRESS, ~a);
        be <= 4'hf;
        bus(1'b1, 8'h10, 8'hff);
        rdchk("addr_masked", IDX_RC_ADDRESS, a);
        rdchk("unmapped", 8'h10, 8'h00);
        idle();
        $display("test refusals done");
        test_done();
    end
endmodule
